// ---- rtl/phybmc_pkg.sv ----
// Purpose: shared constants and types of the basic mode control block
// Assumes: management clock of 250 MHz
// Notes: one control register plus one status register of latched bits
package phybmc_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_LATCH_STATUS = 5'h1E;
   localparam int BIT_RESET = 15;
   localparam int BIT_LOOPBACK = 14;
   localparam int BIT_SPEED_LSB = 13;
   localparam int BIT_ANEG_EN = 12;
   localparam int BIT_POWER_DOWN = 11;
   localparam int BIT_ISOLATE = 10;
   localparam int BIT_ANEG_RESTART = 9;
   localparam int BIT_DUPLEX = 8;
   localparam int BIT_COL_TEST = 7;
   localparam int BIT_SPEED_MSB = 6;
   localparam logic [15:0] CTRL_RESERVED_MASK = 16'h003F;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_RESERVED = 2'h3;
   localparam logic [1:0] SPEED_RESET = SPEED_1000;
   // latched status cell kinds
   localparam logic [1:0] CELL_LATCHED_LOW = 2'h0;
   localparam logic [1:0] CELL_LATCHED_HIGH = 2'h1;
   localparam logic [1:0] CELL_CLEAR_ON_READ = 2'h2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int LOOP_DEAD_US = 500;
   localparam int LOOP_DEAD_CYCLES = LOOP_DEAD_US * CLK_MHZ;
   localparam int SOFT_RST_CYCLES = 16;
   localparam logic [4:0] SOFT_RST_LOAD = 5'(SOFT_RST_CYCLES);
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic loopback;
      logic [1:0] speed;
      logic aneg_en;
      logic power_down;
      logic isolate;
      logic duplex;
      logic col_test;
   } phybmc_ctrl_t;
   typedef struct packed {
      logic dv;
      logic [7:0] data;
   } phybmc_stream_t;
endpackage

// ---- rtl/phybmc_sync.sv ----
// Purpose: three-stage synchroniser for pins
// Assumes: a pin change is taken once stages two and three agree
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module phybmc_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin and result
   input wire logic pin,
   output logic q
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else if (s2_ff == s3_ff) begin
         q <= s3_ff;
      end
   end
endmodule // phybmc_sync

// ---- rtl/phybmc_latch_cell.sv ----
// Purpose: one status bit of latched-low, latched-high or clear-on-read kind
// Assumes: rd is a one-cycle management read pulse of the holding register
// Notes: an event in the read cycle is kept, the set beats the clear
`timescale 1ns/1ns
module phybmc_latch_cell #(
   parameter logic [1:0] KIND = phybmc_pkg::CELL_LATCHED_LOW
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // condition and read strobe
   input wire logic cond,
   input wire logic rd,
   output logic q
);
   logic held_ff;
   logic event_hit;
   assign event_hit = (KIND == phybmc_pkg::CELL_LATCHED_LOW) ? ~cond : cond;
   always_ff @(posedge clk) begin
      if (rst) begin
         held_ff <= 1'b0;
      end else if (event_hit) begin
         held_ff <= 1'b1;
      end else if (rd) begin
         held_ff <= 1'b0;
      end
   end
   always_comb begin
      case (KIND)
         phybmc_pkg::CELL_LATCHED_LOW: q = cond & ~held_ff;
         phybmc_pkg::CELL_LATCHED_HIGH: q = cond | held_ff;
         default: q = held_ff;
      endcase
   end
endmodule // phybmc_latch_cell

// ---- rtl/phybmc_top.sv ----
// Purpose: basic mode control register of a 10/100/1000 transceiver
// Assumes: management access by write/read strobes on MCLK, straps and power-down pin asynchronous
// Notes: analog line side is modelled as a byte stream on MCLK
// Operation
// - bit 15 write one starts reset, reads one until done, then clears
// - software reset reloads strap-derived settings from the strap pins
// - bit 14 one loops MAC transmit data back to MAC receive
// - after loopback enable receive data may be withheld up to 500 us
// - aneg off: bits 6,13 force speed 1000/100/10, code 11 reserved
// - bit 12 resets from strap; when set bits 13 and 8 are ignored
// - aneg off: bit 8 forces full (1) or half (0) duplex, strap reset
// - bit 11 powers the transceiver down, register access stays alive
// - power down is bit OR active-low pin; pin makes bit read set
// - bit 10 isolates the MAC data interface, management keeps working
// - bit 9 restarts aneg when enabled, reads one until initiated; else ignored
// - writing zero to bit 9 never disturbs negotiation in progress
// - collision test: collision within 512 bit times of tx enable, off within 4
// - bits 5 to 0 ignore writes and read zero
// - speed msb resets one; bits 12 and 8 load from straps; other control bits reset zero
// - self-clearing bits set on event and clear alone when it ends
// - latched-low bits hold zero until read, then follow condition
// - latched-high bits hold one until read, then follow condition
// - clear-on-read bits return value then clear on that read
// - permanent bits read fixed value; strap bits load from pins after reset
`timescale 1ns/1ns
module phybmc_top #(
   parameter int LOOP_DEAD_CYCLES = phybmc_pkg::LOOP_DEAD_CYCLES
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // management access
   input wire logic [4:0] MGMT_ADDR,
   input wire logic MGMT_WR,
   input wire logic MGMT_RD,
   input wire logic [15:0] MGMT_WDATA,
   output logic [15:0] MGMT_RDATA,
   // straps and power-down pin
   input wire logic STRAP_ANEG_EN,
   input wire logic STRAP_DUPLEX,
   input wire logic POWER_DOWN_PIN_N,
   // mac side
   input wire logic TX_EN,
   input wire logic [7:0] TXD,
   output logic RX_DV,
   output logic [7:0] RXD,
   output logic COL,
   output logic MAC_OE,
   // line side
   input wire logic LINE_RX_DV,
   input wire logic [7:0] LINE_RXD,
   output logic LINE_TX_EN,
   output logic [7:0] LINE_TXD,
   // negotiation engine
   input wire logic AN_INITIATED,
   input wire logic [1:0] AN_SPEED,
   input wire logic AN_DUPLEX,
   output logic AN_ENABLE,
   output logic AN_RESTART,
   // link events and mode
   input wire logic LINK_OK,
   input wire logic REMOTE_FAULT,
   input wire logic FALSE_CARRIER,
   output logic [1:0] SPEED,
   output logic FULL_DUPLEX,
   output logic POWER_DOWN,
   output logic RESET_BUSY
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic strap_aneg_s;
   logic strap_dup_s;
   logic pd_pin_n_s;
   phybmc_sync #(.RESET_VAL(1'b0)) u_sync_aneg (.clk(MCLK), .rst(SRST), .pin(STRAP_ANEG_EN), .q(strap_aneg_s));
   phybmc_sync #(.RESET_VAL(1'b0)) u_sync_dup (.clk(MCLK), .rst(SRST), .pin(STRAP_DUPLEX), .q(strap_dup_s));
   phybmc_sync #(.RESET_VAL(1'b1)) u_sync_pd (.clk(MCLK), .rst(SRST), .pin(POWER_DOWN_PIN_N), .q(pd_pin_n_s));
   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic rd_stat;
   logic busy_ff;
   logic sw_rst_ff;
   logic [4:0] rst_cnt_ff;
   phybmc_pkg::phybmc_ctrl_t ctrl_ff;
   logic restart_ff;
   // writes during reset are dropped so defaults settle cleanly
   assign wr_ctrl = MGMT_WR & ~busy_ff & (MGMT_ADDR == phybmc_pkg::ADDR_BASIC_MODE_CONTROL);
   assign rd_stat = MGMT_RD & (MGMT_ADDR == phybmc_pkg::ADDR_LATCH_STATUS);

   // ----------------------------------------------------------------
   // reset sequencing
   // ----------------------------------------------------------------
   // hardware reset also runs the counter so synced straps are settled before loading
   // reset bit self-clear
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         busy_ff <= 1'b1;
         rst_cnt_ff <= phybmc_pkg::SOFT_RST_LOAD;
      end else if (wr_ctrl && MGMT_WDATA[phybmc_pkg::BIT_RESET]) begin
         busy_ff <= 1'b1;
         rst_cnt_ff <= phybmc_pkg::SOFT_RST_LOAD;
      end else if (busy_ff) begin
         rst_cnt_ff <= rst_cnt_ff - 5'h01;
         busy_ff <= (rst_cnt_ff != 5'h01);
      end
   end
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         sw_rst_ff <= 1'b0;
      end else if (wr_ctrl && MGMT_WDATA[phybmc_pkg::BIT_RESET]) begin
         sw_rst_ff <= 1'b1;
      end else if (busy_ff && rst_cnt_ff == 5'h01) begin
         sw_rst_ff <= 1'b0;
      end
   end
   logic rst_done;
   assign rst_done = busy_ff & (rst_cnt_ff == 5'h01);
   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   logic [1:0] wr_speed;
   assign wr_speed = {MGMT_WDATA[phybmc_pkg::BIT_SPEED_MSB], MGMT_WDATA[phybmc_pkg::BIT_SPEED_LSB]};
   always_ff @(posedge MCLK) begin
      if (SRST || (busy_ff && !rst_done)) begin
         ctrl_ff.loopback <= 1'b0;
         ctrl_ff.speed <= phybmc_pkg::SPEED_RESET;
         ctrl_ff.power_down <= 1'b0;
         ctrl_ff.isolate <= 1'b0;
         ctrl_ff.col_test <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_ff.loopback <= MGMT_WDATA[phybmc_pkg::BIT_LOOPBACK];
         ctrl_ff.power_down <= MGMT_WDATA[phybmc_pkg::BIT_POWER_DOWN];
         ctrl_ff.isolate <= MGMT_WDATA[phybmc_pkg::BIT_ISOLATE];
         ctrl_ff.col_test <= MGMT_WDATA[phybmc_pkg::BIT_COL_TEST];
         if (wr_speed != phybmc_pkg::SPEED_RESERVED) begin
            ctrl_ff.speed <= wr_speed;
         end
      end
   end
   // strap bits cleared during reset, then loaded from settled pins
   // straps reloaded at reset end
   always_ff @(posedge MCLK) begin
      if (SRST || (busy_ff && !rst_done)) begin
         ctrl_ff.aneg_en <= 1'b0;
         ctrl_ff.duplex <= 1'b0;
      end else if (rst_done) begin
         ctrl_ff.aneg_en <= strap_aneg_s;
         ctrl_ff.duplex <= strap_dup_s;
      end else if (wr_ctrl) begin
         ctrl_ff.aneg_en <= MGMT_WDATA[phybmc_pkg::BIT_ANEG_EN];
         ctrl_ff.duplex <= MGMT_WDATA[phybmc_pkg::BIT_DUPLEX];
      end
   end

   // ----------------------------------------------------------------
   // negotiation restart
   // ----------------------------------------------------------------
   // a written zero is not a clear: the engine's start, aneg off or reset ends the request
   // restart while enabled
   always_ff @(posedge MCLK) begin
      if (SRST || busy_ff) begin
         restart_ff <= 1'b0;
      end else if (wr_ctrl && MGMT_WDATA[phybmc_pkg::BIT_ANEG_RESTART] && ctrl_ff.aneg_en
                   && MGMT_WDATA[phybmc_pkg::BIT_ANEG_EN]) begin
         restart_ff <= 1'b1;
      end else if (AN_INITIATED || !ctrl_ff.aneg_en) begin
         restart_ff <= 1'b0;
      end
   end
   assign AN_RESTART = restart_ff;
   assign AN_ENABLE = ctrl_ff.aneg_en;

   // ----------------------------------------------------------------
   // speed, duplex and power
   // ----------------------------------------------------------------
   logic pd_eff;
   assign pd_eff = ctrl_ff.power_down | ~pd_pin_n_s;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         SPEED <= phybmc_pkg::SPEED_RESET;
         FULL_DUPLEX <= 1'b0;
      end else if (ctrl_ff.aneg_en) begin
         SPEED <= AN_SPEED;
         FULL_DUPLEX <= AN_DUPLEX;
      end else begin
         SPEED <= ctrl_ff.speed;
         FULL_DUPLEX <= ctrl_ff.duplex;
      end
   end
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         POWER_DOWN <= 1'b0;
      end else begin
         POWER_DOWN <= pd_eff;
      end
   end
   assign RESET_BUSY = busy_ff;

   // ----------------------------------------------------------------
   // data paths
   // ----------------------------------------------------------------
   logic [16:0] dead_cnt_ff;
   logic loop_q_ff;
   logic path_off;
   phybmc_pkg::phybmc_stream_t rx_src;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         loop_q_ff <= 1'b0;
      end else begin
         loop_q_ff <= ctrl_ff.loopback;
      end
   end
   // dead time only masks receive valid; a frame still running when it ends is passed on from mid-frame
   // loopback dead time
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         dead_cnt_ff <= 17'h00000;
      end else if (ctrl_ff.loopback && !loop_q_ff) begin
         dead_cnt_ff <= 17'(LOOP_DEAD_CYCLES);
      end else if (dead_cnt_ff != 17'h00000) begin
         dead_cnt_ff <= dead_cnt_ff - 17'h00001;
      end
   end
   assign path_off = ctrl_ff.isolate | pd_eff | busy_ff;
   always_comb begin
      if (ctrl_ff.loopback) begin
         rx_src.dv = TX_EN & (dead_cnt_ff == 17'h00000);
         rx_src.data = TXD;
      end else begin
         rx_src.dv = LINE_RX_DV;
         rx_src.data = LINE_RXD;
      end
   end
   always_ff @(posedge MCLK) begin
      if (SRST || path_off) begin
         RX_DV <= 1'b0;
         RXD <= 8'h00;
      end else begin
         RX_DV <= rx_src.dv;
         RXD <= rx_src.data;
      end
   end
   always_ff @(posedge MCLK) begin
      if (SRST || pd_eff || busy_ff || ctrl_ff.loopback) begin
         LINE_TX_EN <= 1'b0;
         LINE_TXD <= 8'h00;
      end else begin
         LINE_TX_EN <= TX_EN & ~ctrl_ff.isolate;
         LINE_TXD <= TXD;
      end
   end
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         MAC_OE <= 1'b0;
      end else begin
         MAC_OE <= ~path_off;
      end
   end
   // one cycle at 250 MHz equals 4 bit times at the fastest rate
   // collision test echo
   always_ff @(posedge MCLK) begin
      if (SRST || path_off) begin
         COL <= 1'b0;
      end else begin
         COL <= ctrl_ff.col_test & TX_EN;
      end
   end

   // ----------------------------------------------------------------
   // latched status bits
   // ----------------------------------------------------------------
   logic link_q;
   logic fault_q;
   logic fc_q;
   phybmc_latch_cell #(.KIND(phybmc_pkg::CELL_LATCHED_LOW)) u_link (
      .clk(MCLK), .rst(SRST), .cond(LINK_OK), .rd(rd_stat), .q(link_q));
   phybmc_latch_cell #(.KIND(phybmc_pkg::CELL_LATCHED_HIGH)) u_fault (
      .clk(MCLK), .rst(SRST), .cond(REMOTE_FAULT), .rd(rd_stat), .q(fault_q));
   phybmc_latch_cell #(.KIND(phybmc_pkg::CELL_CLEAR_ON_READ)) u_fc (
      .clk(MCLK), .rst(SRST), .cond(FALSE_CARRIER), .rd(rd_stat), .q(fc_q));

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   logic [15:0] ctrl_view;
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[phybmc_pkg::BIT_RESET] = sw_rst_ff;
      ctrl_view[phybmc_pkg::BIT_LOOPBACK] = ctrl_ff.loopback;
      ctrl_view[phybmc_pkg::BIT_SPEED_LSB] = ctrl_ff.speed[0];
      ctrl_view[phybmc_pkg::BIT_ANEG_EN] = ctrl_ff.aneg_en;
      ctrl_view[phybmc_pkg::BIT_POWER_DOWN] = pd_eff;
      ctrl_view[phybmc_pkg::BIT_ISOLATE] = ctrl_ff.isolate;
      ctrl_view[phybmc_pkg::BIT_ANEG_RESTART] = restart_ff;
      ctrl_view[phybmc_pkg::BIT_DUPLEX] = ctrl_ff.duplex;
      ctrl_view[phybmc_pkg::BIT_COL_TEST] = ctrl_ff.col_test;
      ctrl_view[phybmc_pkg::BIT_SPEED_MSB] = ctrl_ff.speed[1];
   end
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         MGMT_RDATA <= 16'h0000;
      end else if (MGMT_RD) begin
         if (MGMT_ADDR == phybmc_pkg::ADDR_BASIC_MODE_CONTROL) begin
            MGMT_RDATA <= ctrl_view & ~phybmc_pkg::CTRL_RESERVED_MASK;
         end else if (rd_stat) begin
            MGMT_RDATA <= {13'h0000, fc_q, fault_q, link_q};
         end else begin
            MGMT_RDATA <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_reset_selfclear:
   assert property (@(posedge MCLK) disable iff (SRST)
      (wr_ctrl && MGMT_WDATA[phybmc_pkg::BIT_RESET]) |=> sw_rst_ff [*8] ##[1:20] !sw_rst_ff)
      else $error("software reset bit did not self-clear");
   a_strap_reload:
   assert property (@(posedge MCLK) disable iff (SRST)
      rst_done |=> (ctrl_ff.aneg_en == $past(strap_aneg_s)) && (ctrl_ff.duplex == $past(strap_dup_s)))
      else $error("straps not reloaded at reset end");
   a_loop_data:
   assert property (@(posedge MCLK) disable iff (SRST)
      (ctrl_ff.loopback && !path_off && dead_cnt_ff == 17'h00000) |=> RXD == $past(TXD))
      else $error("loopback data not returned");
   a_loop_dead:
   assert property (@(posedge MCLK) disable iff (SRST)
      (dead_cnt_ff != 17'h00000 && ctrl_ff.loopback) |=> !RX_DV)
      else $error("receive valid during loopback dead time");
   a_forced_speed:
   assert property (@(posedge MCLK) disable iff (SRST)
      (!ctrl_ff.aneg_en && $stable(ctrl_ff.speed)) |=> SPEED == $past(ctrl_ff.speed))
      else $error("forced speed not applied");
   a_power_or:
   assert property (@(posedge MCLK) disable iff (SRST)
      !pd_pin_n_s |-> ctrl_view[phybmc_pkg::BIT_POWER_DOWN] ##1 POWER_DOWN)
      else $error("power-down pin not honoured");
   a_isolate_off:
   assert property (@(posedge MCLK) disable iff (SRST)
      ctrl_ff.isolate |=> !MAC_OE && !RX_DV && !COL)
      else $error("mac side not isolated");
   a_restart_ignored:
   assert property (@(posedge MCLK) disable iff (SRST)
      (!ctrl_ff.aneg_en && !restart_ff) |=> !restart_ff)
      else $error("restart accepted with negotiation off");
   a_col_test:
   assert property (@(posedge MCLK) disable iff (SRST)
      (ctrl_ff.col_test && TX_EN && !path_off) |=> COL ##1
      (!$past(TX_EN) || !$past(ctrl_ff.col_test) || COL || $past(path_off)))
      else $error("collision test echo wrong");
   a_reserved_zero:
   assert property (@(posedge MCLK) disable iff (SRST)
      $past(MGMT_RD && MGMT_ADDR == phybmc_pkg::ADDR_BASIC_MODE_CONTROL) |-> MGMT_RDATA[5:0] == 6'h00)
      else $error("reserved bits read non-zero");
endmodule // phybmc_top

// ---- tb/phybmc_an_model.sv ----
// Purpose: negotiation engine standing behind the control register
// Assumes: restart is a level held until initiated is returned
// Notes: answers slowly on purpose so a pending restart can be read back
`timescale 1ns/1ns
module phybmc_an_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // negotiation handshake
   input wire logic restart,
   output logic initiated,
   output logic [1:0] speed,
   output logic duplex
);
   logic [2:0] wait_ff;
   // speed result differs from the forced 10 setting in place when the bench enables negotiation
   assign speed = phybmc_pkg::SPEED_100;
   assign duplex = 1'b1;
   always_ff @(posedge clk) begin
      if (rst || !restart) begin
         wait_ff <= 3'h0;
         initiated <= 1'b0;
      end else if (wait_ff == 3'h6) begin
         initiated <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 3'h1;
      end
   end
endmodule // phybmc_an_model

// ---- tb/test_phy_basic_mode_control.sv ----
// Purpose: register level test of the basic mode control block
// Assumes: strobe bus on MCLK, read data sampled a cycle after the read edge
// Notes: loopback dead time shortened to 20 cycles
`timescale 1ns/1ns
module test_phy_basic_mode_control;
   logic MCLK = 0, SRST = 1, MGMT_WR = 0, MGMT_RD = 0, STRAP_ANEG_EN = 0, STRAP_DUPLEX = 1;
   logic POWER_DOWN_PIN_N = 1, TX_EN = 0, LINK_OK = 1, REMOTE_FAULT = 0, FALSE_CARRIER = 0, LINE_RX_DV = 0;
   logic [4:0] MGMT_ADDR = 5'h00;
   logic [15:0] MGMT_WDATA = 16'h0000, MGMT_RDATA;
   logic [7:0] TXD = 8'h00, LINE_RXD = 8'h00, RXD, LINE_TXD;
   logic RX_DV, COL, MAC_OE, LINE_TX_EN, AN_INITIATED, AN_DUPLEX, AN_ENABLE, AN_RESTART;
   logic FULL_DUPLEX, POWER_DOWN, RESET_BUSY;
   logic [1:0] AN_SPEED, SPEED;
   int fail_count = 0, checks_done = 0;
   always #2 MCLK = ~MCLK;
   phybmc_top #(.LOOP_DEAD_CYCLES(20)) DUT (.MCLK(MCLK), .SRST(SRST), .MGMT_ADDR(MGMT_ADDR),
      .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD), .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA),
      .STRAP_ANEG_EN(STRAP_ANEG_EN), .STRAP_DUPLEX(STRAP_DUPLEX), .POWER_DOWN_PIN_N(POWER_DOWN_PIN_N),
      .TX_EN(TX_EN), .TXD(TXD), .RX_DV(RX_DV), .RXD(RXD), .COL(COL), .MAC_OE(MAC_OE),
      .LINE_RX_DV(LINE_RX_DV), .LINE_RXD(LINE_RXD), .LINE_TX_EN(LINE_TX_EN), .LINE_TXD(LINE_TXD),
      .AN_INITIATED(AN_INITIATED), .AN_SPEED(AN_SPEED), .AN_DUPLEX(AN_DUPLEX), .AN_ENABLE(AN_ENABLE),
      .AN_RESTART(AN_RESTART), .LINK_OK(LINK_OK), .REMOTE_FAULT(REMOTE_FAULT),
      .FALSE_CARRIER(FALSE_CARRIER), .SPEED(SPEED), .FULL_DUPLEX(FULL_DUPLEX),
      .POWER_DOWN(POWER_DOWN), .RESET_BUSY(RESET_BUSY));
   phybmc_an_model an_model (.clk(MCLK), .rst(SRST), .restart(AN_RESTART),
      .initiated(AN_INITIATED), .speed(AN_SPEED), .duplex(AN_DUPLEX));
   // ----------------------------------------------------------------
   // access and check tasks
   // ----------------------------------------------------------------
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask
   task ck(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] d);
      @(posedge MCLK);
      MGMT_ADDR <= 5'h00;
      MGMT_WDATA <= d;
      MGMT_WR <= 1'b1;
      @(posedge MCLK);
      MGMT_WR <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
      @(posedge MCLK);
      MGMT_ADDR <= a;
      MGMT_RD <= 1'b1;
      @(posedge MCLK);
      MGMT_RD <= 1'b0;
      tick(1);
      ck(MGMT_RDATA & m, exp & m);
   endtask
   task wait_idle;
      int n;
      n = 0;
      while (RESET_BUSY !== 1'b0 && n < 100) begin
         tick(1);
         n++;
      end
      if (n >= 100) begin
         fail_count++;
         wrap_up;
      end
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      logic [15:0] d;
      repeat (6) @(posedge MCLK);
      SRST <= 1'b0;
      wait_idle;
      rd(5'h00, 16'h0140, 16'hFFFF);
      ck({14'h0, SPEED}, 16'h0002);
      done("reset");
      for (int i = 0; i < 3; i++) begin
         d = (i[0] ? 16'h2000 : 16'h0000) | (i[1] ? 16'h0040 : 16'h0000);
         wr(d | 16'h003F);
         rd(5'h00, d, 16'hFFFF);
         ck({14'h0, SPEED}, 16'(i));
      end
      wr(16'h2040);
      rd(5'h00, 16'h0040, 16'hFFFF);
      wr(16'h0100);
      tick(2);
      ck({15'h0, FULL_DUPLEX}, 16'h0001);
      ck({14'h0, SPEED}, 16'h0000);
      done("forced mode");
      wr(16'h1000);
      tick(2);
      ck({14'h0, SPEED}, 16'h0001);
      ck({15'h0, FULL_DUPLEX}, 16'h0001);
      ck({15'h0, AN_ENABLE}, 16'h0001);
      wr(16'h1200);
      rd(5'h00, 16'h1200, 16'hFFFF);
      tick(12);
      rd(5'h00, 16'h1000, 16'hFFFF);
      wr(16'h0200);
      rd(5'h00, 16'h0000, 16'hFFFF);
      ck({15'h0, AN_RESTART}, 16'h0000);
      done("negotiation");
      wr(16'h0800);
      tick(3);
      ck({POWER_DOWN, MAC_OE}, 16'h0002);
      rd(5'h00, 16'h0800, 16'hFFFF);
      wr(16'h0000);
      POWER_DOWN_PIN_N <= 1'b0;
      tick(8);
      ck({15'h0, POWER_DOWN}, 16'h0001);
      rd(5'h00, 16'h0800, 16'hFFFF);
      @(posedge MCLK) POWER_DOWN_PIN_N <= 1'b1;
      tick(8);
      ck({15'h0, POWER_DOWN}, 16'h0000);
      wr(16'h0400);
      tick(3);
      ck({15'h0, MAC_OE}, 16'h0000);
      rd(5'h00, 16'h0400, 16'hFFFF);
      wr(16'h0000);
      tick(3);
      ck({15'h0, MAC_OE}, 16'h0001);
      done("power and isolate");
      wr(16'h0080);
      TX_EN <= 1'b1;
      TXD <= 8'h3C;
      LINE_RX_DV <= 1'b1;
      LINE_RXD <= 8'h5A;
      tick(3);
      ck({15'h0, COL}, 16'h0001);
      ck({7'h0, LINE_TX_EN, LINE_TXD}, 16'h013C);
      ck({7'h0, RX_DV, RXD}, 16'h015A);
      @(posedge MCLK) TX_EN <= 1'b0;
      LINE_RX_DV <= 1'b0;
      tick(3);
      ck({15'h0, COL}, 16'h0000);
      wr(16'h4000);
      TX_EN <= 1'b1;
      TXD <= 8'hA5;
      tick(10);
      ck({RX_DV, LINE_TX_EN}, 16'h0000);
      n = 0;
      while (RX_DV !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      if (n >= 60) begin
         fail_count++;
         wrap_up;
      end
      ck(16'(n), 16'h000C);
      ck({8'h0, RXD}, 16'h00A5);
      @(posedge MCLK) TX_EN <= 1'b0;
      wr(16'h0000);
      done("collision and loopback");
      @(posedge MCLK) STRAP_ANEG_EN <= 1'b1;
      tick(8);
      wr(16'h8000);
      wr(16'h4000);
      rd(5'h00, 16'h8000, 16'h8000);
      wait_idle;
      rd(5'h00, 16'h1140, 16'hFFFF);
      done("soft reset");
      rd(5'h1E, 16'h0001, 16'hFFFF);
      @(posedge MCLK);
      LINK_OK <= 1'b0;
      REMOTE_FAULT <= 1'b1;
      FALSE_CARRIER <= 1'b1;
      @(posedge MCLK);
      LINK_OK <= 1'b1;
      REMOTE_FAULT <= 1'b0;
      FALSE_CARRIER <= 1'b0;
      tick(2);
      rd(5'h1E, 16'h0006, 16'hFFFF);
      rd(5'h1E, 16'h0001, 16'hFFFF);
      rd(5'h05, 16'h0000, 16'hFFFF);
      done("status");
      wrap_up;
   end
endmodule // test_phy_basic_mode_control
